//--- verilog/autoneg_defines.svh
`ifndef AUTONEG_DEFINES_SVH
`define AUTONEG_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_ADV 8'h04
`define OFS_NP_TX 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RX_WORD 8'h10
`define OFS_ACK_CNT 8'h14

// Control register fields
`define CTRL_AN_EN 0
`define CTRL_RESTART 1
`define CTRL_NP_CAP 2
`define CTRL_SELECT 3
`define CTRL_TECH_LO 4
`define CTRL_TECH_HI 5
`define CTRL_RESET 6'h01

// Status register fields
`define ST_ABIL_MATCH 0
`define ST_ACK_MATCH 1
`define ST_CONS_MATCH 2
`define ST_SINGLE_READY 3
`define ST_ACK_FINISHED 4
`define ST_PARTNER_NP 5
`define ST_NP_WRITTEN 6
`define ST_BASE_PAGE 7
`define ST_STATE_LO 8
`define ST_STATE_HI 9

// Code word bit indices
`define BIT_NEXT_PAGE 15
`define BIT_ACK 14
`define BIT_REMOTE_FAULT 13
`define ADV_RESET 16'h0001
`define NP_TX_RESET 16'h2001

// Chosen technology codes
`define TECH_10T 2'h0
`define TECH_TX 2'h1
`define TECH_T4 2'h2

// Channel indices on the link
`define CH_PULSE 0
`define CH_FULL 1
`define CH_TX 2
`define CH_T4 3
`define NUM_CH 4

`endif

//--- verilog/autoneg_pkg.sv
package autoneg_pkg;
  typedef enum logic [1:0] {LS_FAIL, LS_READY, LS_OK} link_status_t;
  typedef enum logic [1:0] {LC_SCAN, LC_DISABLE, LC_ENABLE} link_control_t;
  typedef enum logic [1:0] {AN_DISABLE, AN_SCAN, AN_LINK} an_state_t;
endpackage

//--- verilog/autoneg_link_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_defines.svh"
interface autoneg_link_if;
  import autoneg_pkg::*;
  link_status_t link_status [`NUM_CH];
  link_control_t link_control [`NUM_CH];
  modport device (input link_status, output link_control);
  modport pma (output link_status, input link_control);
endinterface
`default_nettype wire

//--- verilog/word_match.sv
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_defines.svh"
module word_match (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  output logic ability_match,
  output logic ack_match,
  output logic consistency_match
);
  logic [15:0] prev_reg, prev_next;
  logic have_reg, have_next;
  logic [1:0] abil_cnt_reg, abil_cnt_next;
  logic [1:0] ack_cnt_reg, ack_cnt_next;
  logic [15:0] abil_word_reg, abil_word_next;
  logic [15:0] ack_word_reg, ack_word_next;
  logic cons_reg, cons_next;

  function automatic logic same_no_ack(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] m;
    m = 16'hffff;
    m[`BIT_ACK] = 1'b0;
    same_no_ack = ((a & m) == (b & m));
  endfunction

  always_comb begin
    prev_next = prev_reg;
    have_next = have_reg;
    abil_cnt_next = abil_cnt_reg;
    ack_cnt_next = ack_cnt_reg;
    abil_word_next = abil_word_reg;
    ack_word_next = ack_word_reg;
    if (clear) begin
      have_next = 1'b0;
      abil_cnt_next = 2'h0;
      ack_cnt_next = 2'h0;
    end else if (rx_word_valid) begin
      prev_next = rx_word;
      have_next = 1'b1;
      // Overlapping windows: each word equal to the one before apart from the ack bit extends the running count, which stops at 2
      if (have_reg && same_no_ack(rx_word, prev_reg)) begin
        if (abil_cnt_reg != 2'h2)
          abil_cnt_next = abil_cnt_reg + 2'h1;
      end else begin
        abil_cnt_next = 2'h0;
      end
      if (have_reg && rx_word[`BIT_ACK] && rx_word == prev_reg) begin
        if (ack_cnt_reg != 2'h2)
          ack_cnt_next = ack_cnt_reg + 2'h1;
      end else begin
        ack_cnt_next = 2'h0;
      end
      if (abil_cnt_next == 2'h2 && abil_cnt_reg != 2'h2)
        abil_word_next = rx_word;
      if (ack_cnt_next == 2'h2 && ack_cnt_reg != 2'h2)
        ack_word_next = rx_word;
    end
    cons_next = (abil_cnt_next == 2'h2) && (ack_cnt_next == 2'h2) &&
                same_no_ack(abil_word_next, ack_word_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 16'h0000;
      have_reg <= 1'b0;
      abil_cnt_reg <= 2'h0;
      ack_cnt_reg <= 2'h0;
      abil_word_reg <= 16'h0000;
      ack_word_reg <= 16'h0000;
      cons_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      have_reg <= have_next;
      abil_cnt_reg <= abil_cnt_next;
      ack_cnt_reg <= ack_cnt_next;
      abil_word_reg <= abil_word_next;
      ack_word_reg <= ack_word_next;
      cons_reg <= cons_next;
    end
  end

  assign ability_match = (abil_cnt_reg == 2'h2);
  assign ack_match = (ack_cnt_reg == 2'h2);
  assign consistency_match = cons_reg;
endmodule
`default_nettype wire

//--- verilog/autoneg_device_end.sv
// Overview of operation
// - Advertised ability word held in register
// - Next-page bit only with three flags
// - Base word stored apart from next page
// - PMA status is READY, OK or FAIL
// - Ignore carrier and data unless OK
// - PMAs always report their status
// - Drive scan, disable or enable command
// - Scan: find carrier, report READY only
// - Disable halts PMA processing
// - Enable only the one chosen PMA
// - Reset with negotiation on disables all
// - Negotiation off: command is our choice
// - Unassigned variables take their defaults
// - Negotiation state machine present: disable, scan, link
// - Ability match on three words equal save the ack bit
// - Ack match on three acked words
// - Ack finished after counted acked words
// - Code words are 16-bit registers
// - 10BASE-T chosen enables full checker
// - Single ready: idle, exactly one READY
// - Consistency: ability and ack words equal save the ack bit
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_defines.svh"
module autoneg_device_end #(
  parameter int ACK_CNT_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic rx_idle,
  input wire logic tx_take,
  output logic [15:0] tx_word,
  autoneg_link_if.device link
);
  import autoneg_pkg::*;

  logic [5:0] ctrl_reg, ctrl_next;
  logic restart_reg, restart_next;
  logic [15:0] adv_reg, adv_next;
  logic [15:0] np_tx_reg, np_tx_next;
  logic np_written_reg, np_written_next;
  logic base_page_reg, base_page_next;
  logic partner_np_reg, partner_np_next;
  logic [15:0] rx_last_reg, rx_last_next;
  logic [ACK_CNT_W-1:0] ack_cnt_reg, ack_cnt_next;
  logic ack_armed_reg, ack_armed_next;
  logic ack_fin_reg, ack_fin_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [15:0] tx_word_reg, tx_word_next;
  logic single_reg, single_next;
  an_state_t state_reg, state_next;
  link_control_t ctl_reg [`NUM_CH];
  link_control_t ctl_next [`NUM_CH];
  logic abil_match, ack_match, cons_match;
  logic wr_en, rd_en, np_allowed;
  logic [1:0] ready_cnt;
  logic [15:0] src_word;

  function automatic int tech_to_ch(input logic [1:0] tech);
    unique case (tech)
      `TECH_10T: tech_to_ch = `CH_FULL;
      `TECH_TX: tech_to_ch = `CH_TX;
      `TECH_T4: tech_to_ch = `CH_T4;
      default: tech_to_ch = `CH_PULSE;
    endcase
  endfunction

  function automatic logic is_ready(input link_status_t s);
    is_ready = (s == LS_READY);
  endfunction

  word_match u_match (
    .pclk(pclk),
    .presetn(presetn),
    .clear(restart_reg),
    .rx_word(rx_word),
    .rx_word_valid(rx_word_valid),
    .ability_match(abil_match),
    .ack_match(ack_match),
    .consistency_match(cons_match)
  );

  assign wr_en = psel && penable && pwrite && pready_reg;
  assign rd_en = psel && !penable && !pwrite;
  assign np_allowed = ctrl_reg[`CTRL_NP_CAP] && partner_np_reg && np_written_reg;

  // Register file and page handling
  always_comb begin
    ctrl_next = ctrl_reg;
    restart_next = 1'b0;
    adv_next = adv_reg;
    np_tx_next = np_tx_reg;
    np_written_next = np_written_reg;
    base_page_next = base_page_reg;
    partner_np_next = partner_np_reg;
    rx_last_next = rx_last_reg;
    ack_cnt_next = ack_cnt_reg;
    ack_armed_next = ack_armed_reg;
    ack_fin_next = ack_fin_reg;
    if (rx_word_valid) begin
      rx_last_next = rx_word;
      if (base_page_reg)
        partner_np_next = rx_word[`BIT_NEXT_PAGE];
    end
    if (tx_take && !base_page_reg) begin
      np_written_next = 1'b0;
    end
    if (tx_take && np_allowed) begin
      base_page_next = 1'b0;
    end
    if (tx_take && ack_armed_reg && tx_word_reg[`BIT_ACK] && ack_cnt_reg != '0) begin
      ack_cnt_next = ack_cnt_reg - 1'b1;
      if (ack_cnt_reg == ACK_CNT_W'(1))
        ack_fin_next = 1'b1;
    end
    if (wr_en) begin
      unique case (paddr)
        `OFS_CTRL: begin
          ctrl_next = pwdata[5:0];
          ctrl_next[`CTRL_RESTART] = 1'b0;
          restart_next = pwdata[`CTRL_RESTART];
        end
        `OFS_ADV: adv_next = pwdata[15:0];
        `OFS_NP_TX: begin
          np_tx_next = pwdata[15:0];
          np_written_next = 1'b1;
        end
        `OFS_ACK_CNT: begin
          ack_cnt_next = pwdata[ACK_CNT_W-1:0];
          ack_armed_next = 1'b1;
          ack_fin_next = (pwdata[ACK_CNT_W-1:0] == '0);
        end
        default: ;
      endcase
    end
    if (restart_reg || state_reg == AN_DISABLE) begin
      base_page_next = 1'b1;
      ack_armed_next = 1'b0;
      ack_fin_next = 1'b0;
    end
  end

  // Bus answer and transmit word
  always_comb begin
    prdata_next = 32'h0000_0000;
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      unique case (paddr)
        `OFS_CTRL: prdata_next[5:0] = ctrl_reg;
        `OFS_ADV: prdata_next[15:0] = adv_reg;
        `OFS_NP_TX: prdata_next[15:0] = np_tx_reg;
        `OFS_STATUS: begin
          prdata_next[`ST_ABIL_MATCH] = abil_match;
          prdata_next[`ST_ACK_MATCH] = ack_match;
          prdata_next[`ST_CONS_MATCH] = cons_match;
          prdata_next[`ST_SINGLE_READY] = single_reg;
          prdata_next[`ST_ACK_FINISHED] = ack_fin_reg;
          prdata_next[`ST_PARTNER_NP] = partner_np_reg;
          prdata_next[`ST_NP_WRITTEN] = np_written_reg;
          prdata_next[`ST_BASE_PAGE] = base_page_reg;
          prdata_next[`ST_STATE_HI:`ST_STATE_LO] = state_reg;
        end
        `OFS_RX_WORD: prdata_next[15:0] = rx_last_reg;
        `OFS_ACK_CNT: prdata_next[ACK_CNT_W-1:0] = ack_cnt_reg;
        default: pslverr_next = 1'b1;
      endcase
      if (!rd_en)
        prdata_next = 32'h0000_0000;
    end
    src_word = base_page_reg ? adv_reg : np_tx_reg;
    tx_word_next = src_word;
    tx_word_next[`BIT_NEXT_PAGE] = src_word[`BIT_NEXT_PAGE] && np_allowed;
    tx_word_next[`BIT_ACK] = ack_match && !ack_fin_reg;
  end

  // Link command state machine
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < `NUM_CH; i++)
      ctl_next[i] = LC_DISABLE;
    ready_cnt = 2'h0;
    if (is_ready(link.link_status[`CH_PULSE]))
      ready_cnt = ready_cnt + 2'h1;
    if (is_ready(link.link_status[`CH_TX]))
      ready_cnt = ready_cnt + 2'h1;
    if (is_ready(link.link_status[`CH_T4]))
      ready_cnt = ready_cnt + 2'h1;
    single_next = rx_idle && ready_cnt == 2'h1;
    unique case (state_reg)
      AN_DISABLE: begin
        if (ctrl_reg[`CTRL_AN_EN] && !restart_reg)
          state_next = AN_SCAN;
      end
      AN_SCAN: begin
        if (restart_reg || !ctrl_reg[`CTRL_AN_EN])
          state_next = AN_DISABLE;
        else if (ctrl_reg[`CTRL_SELECT])
          state_next = AN_LINK;
      end
      AN_LINK: begin
        if (restart_reg || !ctrl_reg[`CTRL_AN_EN] || !ctrl_reg[`CTRL_SELECT])
          state_next = AN_DISABLE;
      end
    endcase
    unique case (state_next)
      AN_SCAN: begin
        ctl_next[`CH_PULSE] = LC_SCAN;
        ctl_next[`CH_TX] = LC_SCAN;
        ctl_next[`CH_T4] = LC_SCAN;
      end
      AN_LINK: ctl_next[tech_to_ch(ctrl_reg[`CTRL_TECH_HI:`CTRL_TECH_LO])] = LC_ENABLE;
      AN_DISABLE: ;
    endcase
    if (!ctrl_reg[`CTRL_AN_EN] && ctrl_reg[`CTRL_SELECT])
      ctl_next[tech_to_ch(ctrl_reg[`CTRL_TECH_HI:`CTRL_TECH_LO])] = LC_ENABLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      restart_reg <= 1'b0;
      adv_reg <= `ADV_RESET;
      np_tx_reg <= `NP_TX_RESET;
      np_written_reg <= 1'b0;
      base_page_reg <= 1'b1;
      partner_np_reg <= 1'b0;
      rx_last_reg <= 16'h0000;
      ack_cnt_reg <= '0;
      ack_armed_reg <= 1'b0;
      ack_fin_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      tx_word_reg <= 16'h0000;
      single_reg <= 1'b0;
      state_reg <= AN_DISABLE;
      for (int i = 0; i < `NUM_CH; i++)
        ctl_reg[i] <= LC_DISABLE;
    end else begin
      ctrl_reg <= ctrl_next;
      restart_reg <= restart_next;
      adv_reg <= adv_next;
      np_tx_reg <= np_tx_next;
      np_written_reg <= np_written_next;
      base_page_reg <= base_page_next;
      partner_np_reg <= partner_np_next;
      rx_last_reg <= rx_last_next;
      ack_cnt_reg <= ack_cnt_next;
      ack_armed_reg <= ack_armed_next;
      ack_fin_reg <= ack_fin_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      tx_word_reg <= tx_word_next;
      single_reg <= single_next;
      state_reg <= state_next;
      ctl_reg <= ctl_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_word = tx_word_reg;
  assign link.link_control = ctl_reg;
endmodule
`default_nettype wire

//--- verilog/pma_link_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_defines.svh"
module pma_link_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`NUM_CH-1:0] carrier_pin,
  output logic [`NUM_CH-1:0] processing_active,
  output logic [`NUM_CH-1:0] carrier_valid,
  autoneg_link_if.pma link
);
  import autoneg_pkg::*;

  logic [`NUM_CH-1:0] s1_reg, s2_reg, s3_reg, carrier_reg, carrier_next;
  logic [`NUM_CH-1:0] active_reg, active_next, valid_reg, valid_next;
  link_status_t st_reg [`NUM_CH];
  link_status_t st_next [`NUM_CH];

  always_comb begin
    carrier_next = carrier_reg;
    for (int i = 0; i < `NUM_CH; i++) begin
      if (s2_reg[i] == s3_reg[i])
        carrier_next[i] = s3_reg[i];
      st_next[i] = LS_FAIL;
      active_next[i] = 1'b0;
      valid_next[i] = 1'b0;
      unique case (link.link_control[i])
        LC_SCAN: if (carrier_reg[i]) st_next[i] = LS_READY;
        LC_DISABLE: st_next[i] = LS_FAIL;
        LC_ENABLE: begin
          if (carrier_reg[i]) begin
            st_next[i] = LS_OK;
            active_next[i] = 1'b1;
            valid_next[i] = 1'b1;
          end
        end
        default: st_next[i] = LS_FAIL;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      carrier_reg <= '0;
      active_reg <= '0;
      valid_reg <= '0;
      for (int i = 0; i < `NUM_CH; i++)
        st_reg[i] <= LS_FAIL;
    end else begin
      s1_reg <= carrier_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      carrier_reg <= carrier_next;
      active_reg <= active_next;
      valid_reg <= valid_next;
      st_reg <= st_next;
    end
  end

  assign processing_active = active_reg;
  assign carrier_valid = valid_reg;
  assign link.link_status = st_reg;
endmodule
`default_nettype wire

//--- sim/autoneg_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_defines.svh"
module autoneg_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input var autoneg_pkg::link_status_t link_status [`NUM_CH],
  input var autoneg_pkg::link_control_t link_control [`NUM_CH],
  input wire logic [`NUM_CH-1:0] processing_active,
  input wire logic [`NUM_CH-1:0] carrier_valid
);
  import autoneg_pkg::*;
  logic [`NUM_CH-1:0] en;
  logic [`NUM_CH-1:0] dis;
  always_comb begin
    for (int c = 0; c < `NUM_CH; c++) begin
      en[c] = link_control[c] == LC_ENABLE;
      dis[c] = link_control[c] == LC_DISABLE;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_single_enable: assert property ($onehot0(en))
    else $error("more than one channel enabled");
  a_reset_disables: assert property ($rose(presetn) |-> &dis)
    else $error("channel not disabled out of reset");
  for (genvar c = 0; c < `NUM_CH; c++) begin : g_ch
    sequence s_ready_enabled;
      link_status[c] == LS_READY && en[c];
    endsequence
    sequence s_not_ok;
      (link_status[c] != LS_OK) [*2];
    endsequence
    sequence s_not_enabled;
      (!en[c]) [*2];
    endsequence
    a_disable_fails: assert property (dis[c] |=> link_status[c] == LS_FAIL)
      else $error("disabled channel not failed");
    a_scan_not_ok: assert property (link_control[c] == LC_SCAN |=> link_status[c] != LS_OK)
      else $error("scanned channel reports ok");
    a_ok_needs_enable: assert property (link_status[c] == LS_OK |-> $past(en[c]))
      else $error("ok without enable");
    a_enable_gives_ok: assert property (s_ready_enabled |=> link_status[c] == LS_OK)
      else $error("enabled ready channel not ok");
    a_valid_only_ok: assert property (s_not_ok |-> !carrier_valid[c])
      else $error("carrier valid while not ok");
    a_idle_when_off: assert property (s_not_enabled |-> !processing_active[c])
      else $error("processing while not enabled");
  end
endmodule
`default_nettype wire

//--- sim/test_autoneg_pma_link_interface.sv
`timescale 1ns/10ps
`default_nettype none
`include "autoneg_defines.svh"
module test_autoneg_pma_link_interface;
  import autoneg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rx_word_valid, rx_idle, tx_take, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] rx_word, tx_word;
  logic [`NUM_CH-1:0] carrier_pin, processing_active, carrier_valid;
  int failures, n_compared, ch;

  autoneg_link_if autoneg_link_if_i ();
  autoneg_device_end #(.ACK_CNT_W(4)) autoneg_device_end_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid), .rx_idle(rx_idle), .tx_take(tx_take), .tx_word(tx_word),
    .link(autoneg_link_if_i.device));
  pma_link_end pma_link_end_i (.pclk(pclk), .presetn(presetn), .carrier_pin(carrier_pin),
    .processing_active(processing_active), .carrier_valid(carrier_valid),
    .link(autoneg_link_if_i.pma));
  autoneg_link_asserts autoneg_link_asserts_i (.pclk(pclk), .presetn(presetn),
    .link_status(autoneg_link_if_i.link_status), .link_control(autoneg_link_if_i.link_control),
    .processing_active(processing_active), .carrier_valid(carrier_valid));

  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end

  task close_out;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask

  task waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(d & mask, exp);
  endtask

  task rx(input logic [15:0] w);
    @(posedge pclk);
    rx_word <= w;
    rx_word_valid <= 1;
    @(posedge pclk);
    rx_word_valid <= 0;
  endtask

  task take;
    @(posedge pclk);
    tx_take <= 1;
    @(posedge pclk);
    tx_take <= 0;
    waitc(2);
  endtask

  task ctl_chk(input logic [3:0] en_m, input logic [3:0] scan_m);
    link_control_t x;
    for (int c = 0; c < `NUM_CH; c++) begin
      x = en_m[c] ? LC_ENABLE : (scan_m[c] ? LC_SCAN : LC_DISABLE);
      chk(32'(autoneg_link_if_i.link_control[c]), 32'(x));
    end
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    close_out;
  end

  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_word = 16'h0;
    rx_word_valid = 0;
    rx_idle = 1;
    tx_take = 0;
    carrier_pin = 4'h0;
    failures = 0;
    n_compared = 0;
    waitc(2);
    ctl_chk(4'h0, 4'h0);
    waitc(1);
    presetn <= 1;
    rd(`OFS_CTRL, 32'h3f, 32'h01);
    rd(`OFS_ADV, 32'hffff, 32'h0001);
    rd(`OFS_NP_TX, 32'hffff, 32'h2001);
    // Unmapped place reads zero with an error
    apb(0, 8'h18, 32'h0);
    chk(d, 32'h0);
    chk(e, 32'h1);
    waitc(4);
    ctl_chk(4'h0, 4'hd);
    rd(`OFS_STATUS, 32'h30f, 32'h100);
    // One channel finds carrier
    carrier_pin <= 4'h4;
    waitc(8);
    chk(32'(autoneg_link_if_i.link_status[2]), 32'(LS_READY));
    chk(processing_active, 32'h0);
    rd(`OFS_STATUS, 32'h8, 32'h8);
    rx_idle <= 0;
    rd(`OFS_STATUS, 32'h8, 32'h0);
    rx_idle <= 1;
    carrier_pin <= 4'hc;
    waitc(8);
    rd(`OFS_STATUS, 32'h8, 32'h0);
    // Word matching
    apb(1, `OFS_ADV, 32'h8021);
    waitc(2);
    chk(tx_word, 32'h0021);
    rx(16'h0041);
    rx(16'h4041);
    rd(`OFS_STATUS, 32'h1, 32'h0);
    rx(16'h0041);
    rd(`OFS_STATUS, 32'h1, 32'h1);
    rx(16'h0042);
    rd(`OFS_STATUS, 32'h1, 32'h0);
    repeat (3) rx(16'hc043);
    rd(`OFS_STATUS, 32'h27, 32'h27);
    rd(`OFS_RX_WORD, 32'hffff, 32'hc043);
    waitc(2);
    chk(tx_word, 32'h4021);
    // Next page and acknowledge count
    apb(1, `OFS_NP_TX, 32'h2005);
    apb(1, `OFS_CTRL, 32'h05);
    apb(1, `OFS_ACK_CNT, 32'h2);
    rd(`OFS_STATUS, 32'hd0, 32'hc0);
    chk(tx_word, 32'hc021);
    take();
    chk(tx_word, 32'h6005);
    rd(`OFS_STATUS, 32'hd0, 32'h40);
    take();
    rd(`OFS_STATUS, 32'h50, 32'h10);
    rd(`OFS_ACK_CNT, 32'hf, 32'h0);
    apb(1, `OFS_CTRL, 32'h07);
    waitc(4);
    rd(`OFS_STATUS, 32'h83, 32'h80);
    chk(tx_word & 16'h3fff, 32'h0021);
    rd(`OFS_ADV, 32'hffff, 32'h8021);
    // Negotiated link: ready channel handed over
    apb(1, `OFS_CTRL, 32'h19);
    waitc(4);
    ctl_chk(4'h4, 4'h0);
    chk(32'(autoneg_link_if_i.link_status[2]), 32'(LS_OK));
    rd(`OFS_STATUS, 32'h300, 32'h200);
    // Chosen channel for every technology code
    carrier_pin <= 4'hf;
    for (int t = 0; t < 4; t++) begin
      ch = (t + 1) % 4;
      apb(1, `OFS_CTRL, 32'h8 | (t << 4));
      waitc(8);
      ctl_chk(4'h1 << ch, 4'h0);
      chk(32'(autoneg_link_if_i.link_status[ch]), 32'(LS_OK));
      chk(carrier_valid, 4'h1 << ch);
      chk(processing_active, 4'h1 << ch);
    end
    apb(1, `OFS_CTRL, 32'h0);
    waitc(4);
    ctl_chk(4'h0, 4'h0);
    chk(processing_active, 32'h0);
    chk(32'(autoneg_link_if_i.link_status[2]), 32'(LS_FAIL));
    // Second reset in mid-run
    presetn <= 0;
    waitc(2);
    ctl_chk(4'h0, 4'h0);
    presetn <= 1;
    rd(`OFS_CTRL, 32'h3f, 32'h01);
    waitc(4);
    ctl_chk(4'h0, 4'hd);
    close_out;
  end
endmodule
`default_nettype wire
